//--- rtl/ate_event_gen.sv
`timescale 1ns/1ps
// Function
// - underflow of the down counter pulses the underflow/measure event, any mode
// - width mode: end of the pin's active level pulses the same event
// - period mode: each selected pin edge pulses the same event
// - counter decremented onto compare value A pulses match A while A enabled
// - counter decremented onto compare value B pulses match B while B enabled
// - event logic runs on the timer clock alone, usable as wake source
module ate_event_gen #(
	parameter int CNT_WIDTH = ate_pkg::CNT_WIDTH
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic count_tick,
	input wire logic count_load,
	input wire logic [CNT_WIDTH-1:0] reload_value,
	input wire logic [1:0] mode,
	input wire logic [1:0] edge_select,
	input wire logic active_high,
	input wire logic timer_ext_io_pin,
	input wire logic compare_enable_a,
	input wire logic compare_enable_b,
	input wire logic [CNT_WIDTH-1:0] compare_value_a,
	input wire logic [CNT_WIDTH-1:0] compare_value_b,
	output logic [CNT_WIDTH-1:0] async_down_counter,
	output logic underflow_irq,
	output logic underflow_link,
	output logic match_a_irq,
	output logic match_a_link,
	output logic match_b_irq,
	output logic match_b_link,
	output logic wake_request
);
	typedef struct packed {
		logic [CNT_WIDTH-1:0] count;
		logic underflow;
		logic match_a;
		logic match_b;
		logic wake;
	} ate_state_type;
	ate_state_type state;
	ate_state_type next_state;
	logic pin_rise;
	logic pin_fall;
	logic pin_active;
	logic width_end;
	logic period_edge;
	logic counting;
	logic wraps;
	logic decrement;
	logic any_cause;
	logic [CNT_WIDTH-1:0] next_count;

	ate_pin_edge u_pin_edge (
		.clk_sys(clk_sys),
		.reset(reset),
		.pin(timer_ext_io_pin),
		.rise(pin_rise),
		.fall(pin_fall)
	);

	function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
		edge_hit = (sel == ate_pkg::ATE_EDGE_RISE) ? r :
			(sel == ate_pkg::ATE_EDGE_FALL) ? f : (r | f);
	endfunction : edge_hit

	// A match needs a real decrement, so a reload onto the compare value stays quiet
	function automatic logic match_hit(input logic enable, input logic step,
			input logic [CNT_WIDTH-1:0] value, input logic [CNT_WIDTH-1:0] target);
		match_hit = enable && step && (value == target);
	endfunction : match_hit

	assign pin_active = timer_ext_io_pin ~^ active_high;
	assign width_end = (mode == ate_pkg::ATE_MODE_WIDTH) &&
		(active_high ? pin_fall : pin_rise);
	assign period_edge = (mode == ate_pkg::ATE_MODE_PERIOD) &&
		edge_hit(edge_select, pin_rise, pin_fall);
	// Width mode counts only through the active level of the pin
	assign counting = count_tick &&
		((mode != ate_pkg::ATE_MODE_WIDTH) || pin_active);
	// load wins tick
	// A tick lost to a reload neither counts nor wraps, so no false underflow
	assign decrement = counting && !count_load && !period_edge;
	assign wraps = decrement && (state.count == '0);
	assign any_cause = wraps || width_end || period_edge;

	always_comb begin
		next_state = state;
		next_count = state.count;
		if (count_load || period_edge) begin
			next_count = reload_value;
		end else if (counting) begin
			next_count = state.count - 1'b1;
		end
		next_state.count = next_count;
		next_state.underflow = any_cause;
		next_state.match_a = match_hit(compare_enable_a, decrement, next_count, compare_value_a);
		next_state.match_b = match_hit(compare_enable_b, decrement, next_count, compare_value_b);
		next_state.wake = next_state.underflow || next_state.match_a || next_state.match_b;
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state <= '{count: CNT_WIDTH'(ate_pkg::COUNT_RESET), default: '0};
		end else begin
			state <= next_state;
		end
	end

	assign async_down_counter = state.count;
	assign underflow_irq = state.underflow;
	assign underflow_link = state.underflow;
	assign match_a_irq = state.match_a;
	assign match_a_link = state.match_a;
	assign match_b_irq = state.match_b;
	assign match_b_link = state.match_b;
	assign wake_request = state.wake;

	// Each cause gives its pulse one cycle later
	chk_underflow_on_wrap : assert property (@(posedge clk_sys) disable iff (reset)
		wraps && !count_load |=> underflow_irq)
		else $error("wrap without event");
	chk_width_end_event : assert property (@(posedge clk_sys) disable iff (reset)
		width_end |=> underflow_link)
		else $error("width end missed");
	chk_period_edge_event : assert property (@(posedge clk_sys) disable iff (reset)
		period_edge |=> underflow_irq && async_down_counter == $past(reload_value))
		else $error("period edge missed");
	chk_match_a_cause : assert property (@(posedge clk_sys) disable iff (reset)
		match_a_irq |-> $past(compare_enable_a) && async_down_counter == $past(compare_value_a))
		else $error("bad match A");
	chk_match_b_cause : assert property (@(posedge clk_sys) disable iff (reset)
		match_b_irq |-> $past(compare_enable_b) && async_down_counter == $past(compare_value_b))
		else $error("bad match B");
	chk_wake_follows_events : assert property (@(posedge clk_sys) disable iff (reset)
		wake_request == (underflow_irq || match_a_irq || match_b_irq))
		else $error("wake mismatch");
	chk_underflow_one_cycle : assert property (@(posedge clk_sys) disable iff (reset)
		underflow_irq |=> !underflow_irq || $past(any_cause))
		else $error("underflow stuck");
	chk_link_equals_irq : assert property (@(posedge clk_sys) disable iff (reset)
		underflow_link == underflow_irq && match_a_link == match_a_irq
		&& match_b_link == match_b_irq)
		else $error("link differs");

	// Counter steps, seen from the pins rather than the next-state logic
	chk_load_takes_value : assert property (@(posedge clk_sys) disable iff (reset)
		count_load
		|=> async_down_counter == $past(reload_value))
		else $error("load value lost");
	chk_decrement_step : assert property (@(posedge clk_sys) disable iff (reset)
		decrement
		|=> async_down_counter == $past(async_down_counter) - 1'b1)
		else $error("bad decrement");
	chk_wrap_to_top : assert property (@(posedge clk_sys) disable iff (reset)
		wraps
		|=> async_down_counter == '1)
		else $error("wrap not to top");
	chk_hold_when_idle : assert property (@(posedge clk_sys) disable iff (reset)
		!count_load && !period_edge && !counting
		|=> $stable(async_down_counter))
		else $error("counter moved while idle");
	chk_event_has_cause : assert property (@(posedge clk_sys) disable iff (reset)
		underflow_irq
		|-> $past(any_cause))
		else $error("underflow without cause");

	// Compare gating: no match while disabled or without a decrement
	chk_match_a_gated : assert property (@(posedge clk_sys) disable iff (reset)
		!compare_enable_a
		|=> !match_a_irq)
		else $error("match A while disabled");
	chk_match_b_gated : assert property (@(posedge clk_sys) disable iff (reset)
		!compare_enable_b
		|=> !match_b_irq)
		else $error("match B while disabled");
	chk_match_a_step : assert property (@(posedge clk_sys) disable iff (reset)
		match_a_irq
		|-> $past(decrement))
		else $error("match A without step");
	chk_match_b_step : assert property (@(posedge clk_sys) disable iff (reset)
		match_b_irq
		|-> $past(decrement))
		else $error("match B without step");
	chk_match_a_fires : assert property (@(posedge clk_sys) disable iff (reset)
		decrement && compare_enable_a && (async_down_counter - 1'b1 == compare_value_a)
		|=> match_a_irq)
		else $error("match A missed");
	chk_match_b_fires : assert property (@(posedge clk_sys) disable iff (reset)
		decrement && compare_enable_b && (async_down_counter - 1'b1 == compare_value_b)
		|=> match_b_irq)
		else $error("match B missed");

	// Pin edges judged from the pin itself, independent of the edge finder
	chk_width_end_fires : assert property (@(posedge clk_sys) disable iff (reset)
		mode == ate_pkg::ATE_MODE_WIDTH && timer_ext_io_pin != active_high
		&& $past(timer_ext_io_pin) == active_high
		|=> underflow_irq)
		else $error("width end not seen");
	chk_period_edge_fires : assert property (@(posedge clk_sys) disable iff (reset)
		mode == ate_pkg::ATE_MODE_PERIOD && edge_select == ate_pkg::ATE_EDGE_BOTH
		&& $changed(timer_ext_io_pin)
		|=> underflow_irq)
		else $error("period edge not seen");

	cov_underflow : cover property (@(posedge clk_sys) disable iff (reset) wraps);
	cov_width : cover property (@(posedge clk_sys) disable iff (reset) width_end);
	cov_period : cover property (@(posedge clk_sys) disable iff (reset) period_edge);
	cov_match_ab : cover property (@(posedge clk_sys) disable iff (reset) match_a_irq ##1 match_b_irq);
	cov_load_at_zero : cover property (@(posedge clk_sys) disable iff (reset)
		count_load && count_tick && async_down_counter == '0);
endmodule : ate_event_gen

//--- rtl/ate_pin_edge.sv
`timescale 1ns/1ps
module ate_pin_edge (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic pin,
	output logic rise,
	output logic fall
);
	typedef struct packed {
		logic last;
	} ate_edge_state_type;
	ate_edge_state_type state;
	ate_edge_state_type next_state;

	always_comb begin
		next_state = state;
		next_state.last = pin;
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			// Take the pin level, so a pin high at release gives no false edge
			state <= '{last: pin};
		end else begin
			state <= next_state;
		end
	end

	// Pin is taken as synchronous; flop only to find its edges
	assign rise = pin & ~state.last;
	assign fall = ~pin & state.last;
endmodule : ate_pin_edge

//--- rtl/ate_pkg.sv
package ate_pkg;
	localparam int CNT_WIDTH = 16;
	localparam logic [15:0] COUNT_RESET = 16'hffff;
	localparam logic [15:0] COMPARE_RESET = 16'hffff;
	typedef enum logic [1:0] {
		ATE_MODE_TIMER = 2'h0,
		ATE_MODE_EVENT = 2'h1,
		ATE_MODE_WIDTH = 2'h3,
		ATE_MODE_PERIOD = 2'h2
	} ate_mode_type;
	typedef enum logic [1:0] {
		ATE_EDGE_RISE = 2'h0,
		ATE_EDGE_FALL = 2'h1,
		ATE_EDGE_BOTH = 2'h2
	} ate_edge_type;
endpackage : ate_pkg

//--- verif/ate_event_sink.sv
`timescale 1ns/1ps
module ate_event_sink (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [2:0] irq,
	input wire logic [2:0] link,
	output logic split,
	output int n_events
);
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			split <= 1'b0;
			n_events <= 0;
		end else begin
			split <= split | (irq !== link);
			n_events <= n_events + int'(irq != 3'h0);
		end
	end
endmodule : ate_event_sink

//--- verif/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic clk_sys = 1'b0, reset = 1'b1, tick = 1'b0, load = 1'b0, act = 1'b1, pin = 1'b0;
	logic en_a = 1'b0, en_b = 1'b0, prev = 1'b0, split, wake;
	logic [1:0] mode = 2'h0, esel = 2'h0;
	logic [15:0] rl = 16'h0000, cva = 16'h0000, cvb = 16'h0000, cnt, e_cnt = 16'hffff;
	wire [2:0] irq, link;
	logic [3:0] e_ev = 4'h0;
	int miscompares = 0, n_checks = 0, cycles = 0, n_events;
	int seed = 32'h1e8c575f;
	ate_event_gen i_ate_event_gen (.clk_sys(clk_sys), .reset(reset), .count_tick(tick),
		.count_load(load), .reload_value(rl), .mode(mode), .edge_select(esel),
		.active_high(act), .timer_ext_io_pin(pin), .compare_enable_a(en_a),
		.compare_enable_b(en_b), .compare_value_a(cva), .compare_value_b(cvb),
		.async_down_counter(cnt), .underflow_irq(irq[2]), .underflow_link(link[2]),
		.match_a_irq(irq[1]), .match_a_link(link[1]), .match_b_irq(irq[0]),
		.match_b_link(link[0]), .wake_request(wake));
	ate_event_sink i_ate_event_sink (.clk_sys(clk_sys), .reset(reset), .irq(irq),
		.link(link), .split(split), .n_events(n_events));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	function automatic logic [19:0] ref_next(input logic [15:0] c, input logic p);
		logic run, hit, w_end, uf, ma, mb;
		hit = mode == ate_pkg::ATE_MODE_PERIOD && p != pin
			&& (esel == ate_pkg::ATE_EDGE_BOTH || pin == (esel == ate_pkg::ATE_EDGE_RISE));
		// A load or a period reload in the same cycle keeps the tick from counting
		run = tick && (mode != ate_pkg::ATE_MODE_WIDTH || pin == act) && !load && !hit;
		w_end = mode == ate_pkg::ATE_MODE_WIDTH && p == act && pin != act;
		uf = hit || w_end || (run && c == 16'h0000);
		ma = run && en_a && c - 16'h0001 == cva;
		mb = run && en_b && c - 16'h0001 == cvb;
		return {(load || hit) ? rl : (run ? c - 16'h0001 : c), uf, ma, mb, uf | ma | mb};
	endfunction : ref_next
	task automatic conclude();
		check(16'(split), 16'h0000);
		check(16'(n_events > 0), 16'h0001);
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : conclude
	initial begin
		forever #10 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		prev <= pin;
		{e_cnt, e_ev} <= reset ? {16'hffff, 4'h0} : ref_next(e_cnt, prev);
		if (cycles == 6000) begin
			miscompares++;
			conclude();
		end
	end
	always @(negedge clk_sys) begin
		if (!reset) begin
			check(cnt, e_cnt);
			check(16'({irq[2], link[2]}), {14'h0, {2{e_ev[3]}}});
			check(16'({irq[1], link[1]}), {14'h0, {2{e_ev[2]}}});
			check(16'({irq[0], link[0]}), {14'h0, {2{e_ev[1]}}});
			check(16'(wake), 16'(e_ev[0]));
		end
	end
	initial begin
		logic [31:0] r;
		repeat (8) @(posedge clk_sys);
		#1 reset = 1'b0;
		// Every mode and edge; compare ffff first so a wrap also matches
		cva = 16'hffff;
		for (int m = 0; m < 12; m++) begin
			mode = 2'(m / 3);
			esel = 2'(m % 3);
			act = esel != 2'h1;
			// Reset again in mid-run with the pin high: no false edge may follow
			if (m == 6) begin
				check(16'(split), 16'h0000);
				reset = 1'b1;
				pin = 1'b1;
				repeat (2) @(posedge clk_sys);
				#1 reset = 1'b0;
			end
			repeat (200) begin
				@(posedge clk_sys);
				#1 r = $random(seed);
				// Loads and ticks may coincide, so the reload priority is exercised
				load = r[3:0] == 4'h0;
				tick = r[4];
				rl = 16'(r[9:5]);
				pin = pin ^ (r[13:10] == 4'h0);
				en_a = r[14] | r[15];
				en_b = r[16];
				if (r[20:17] == 4'h0) begin
					cva = 16'(r[24:21]);
					cvb = 16'(r[28:25]);
				end
			end
		end
		conclude();
	end
endmodule : testbench
